//--- tws_two_wire_io.sv
// two-wire serial i/o channel: byte shifter on a clock line and one of two
// selectable open-drain data lines, with register access over avalon-mm
// assumes: pins are pulled up outside; pin inputs are asynchronous
//
// What this block does
// - shift write starts transfer only when enabled
// - start only with clock stopped or high
// - enabling after a shift write starts nothing
// - data pin released for every one bit
// - stop after eight bits, set done flag
// - shift register samples real bus level
// - before/after compare reveals transmit errors
// - compare match flag reports shift register equal to address compare register while enabled; forced low while disabled
// - clock pin has software output latch
// - control bits 0 and 1 set/clear data latch, only between transfers
// - static clock level when idle in output mode
// - output moves on serial clock falling edge
// - input captured on serial clock rising edge
// - most significant bit leaves first
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tws_two_wire_io #(
   parameter int SCK_HALF = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire tws_pkg::tws_addr_t avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire tws_pkg::tws_word_t avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output tws_pkg::tws_word_t avs_readdata,
   output logic avs_waitrequest,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic data_bus_pin_a_in,
   output logic data_bus_pin_a_out,
   output logic data_bus_pin_a_oe,
   input wire logic data_bus_pin_b_in,
   output logic data_bus_pin_b_out,
   output logic data_bus_pin_b_oe,
   output logic irq
);
   import tws_pkg::*;

   function automatic logic hit(input tws_addr_t a, input tws_addr_t ofs);
      return a == ofs;
   endfunction

   // bus side
   logic ack_reg;
   logic access;
   logic take;
   logic rd_take;
   tws_byte_t wbyte;
   tws_byte_t rd_byte;
   logic wr_mode;
   logic wr_bus_ctrl;
   logic wr_shift;
   logic wr_addr_cmp;
   logic wr_clk_latch;
   logic wr_irq_clr;
   logic wr_irq_en;

   // channel state
   tws_byte_t channel_mode_register_reg;
   tws_byte_t serial_shift_register_reg;
   tws_byte_t address_compare_register_reg;
   tws_byte_t tx_copy_reg;
   tws_state_t state_reg;
   tws_state_t state_next;
   logic [2:0] bit_cnt_reg;
   logic serial_output_latch_reg;
   logic clock_pin_output_latch_reg;
   logic compare_match_flag_reg;
   logic sck_prev_reg;
   logic [`TWS_IRQ_W-1:0] irq_stat_reg;
   logic [`TWS_IRQ_W-1:0] irq_en_reg;
   logic [`TWS_IRQ_W-1:0] irq_set;
   logic [`TWS_IRQ_W-1:0] irq_clr;

   logic [2:0] pin_sync;
   logic channel_enable_bit;
   logic int_clk;
   logic pin_sel;
   logic busy;
   logic can_start;
   logic start;
   logic ext_rise;
   logic ext_fall;
   logic sck_rise;
   logic sck_fall;
   logic din;
   logic done_evt;
   logic clk_level;
   logic data_line_set_trigger;
   logic data_line_clear_trigger;

   tws_clk_if clk_bus ();

   tws_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({serial_clock_pin_in, data_bus_pin_b_in, data_bus_pin_a_in}),
      .sync_out(pin_sync)
   );

   tws_clkgen #(
      .HALF(SCK_HALF)
   ) u_clkgen (
      .core_clk(core_clk),
      .rst(rst),
      .clk_port(clk_bus.gen)
   );

   // avalon-mm: one wait state on every access, answer on the second edge
   assign access = avs_read || avs_write;
   assign avs_waitrequest = access && !ack_reg;
   assign take = avs_write && ack_reg && avs_byteenable[0];
   assign rd_take = avs_read && !ack_reg;
   assign wbyte = avs_writedata[7:0];

   assign wr_mode = take && hit(avs_address, `TWS_OFS_MODE);
   assign wr_bus_ctrl = take && hit(avs_address, `TWS_OFS_BUS_CTRL);
   assign wr_shift = take && hit(avs_address, `TWS_OFS_SHIFT);
   assign wr_addr_cmp = take && hit(avs_address, `TWS_OFS_ADDR_CMP);
   assign wr_clk_latch = take && hit(avs_address, `TWS_OFS_CLK_LATCH);
   assign wr_irq_clr = take && hit(avs_address, `TWS_OFS_IRQ_CLR);
   assign wr_irq_en = take && hit(avs_address, `TWS_OFS_IRQ_EN);

   // triggers are write-only strobes and read back as zero
   assign data_line_set_trigger = wr_bus_ctrl && wbyte[`TWS_BC_SET];
   assign data_line_clear_trigger = wr_bus_ctrl && wbyte[`TWS_BC_CLR];

   assign channel_enable_bit = channel_mode_register_reg[`TWS_MODE_EN];
   assign int_clk = channel_mode_register_reg[`TWS_MODE_INTCLK];
   assign pin_sel = channel_mode_register_reg[`TWS_MODE_PINSEL];
   assign busy = (state_reg == ST_SHIFT);

   assign rd_byte =
      hit(avs_address, `TWS_OFS_MODE) ?
         (channel_mode_register_reg
          | ({7'h00, compare_match_flag_reg} << `TWS_MODE_MATCH)
          | ({7'h00, busy} << `TWS_MODE_BUSY)) :
      hit(avs_address, `TWS_OFS_SHIFT) ? serial_shift_register_reg :
      hit(avs_address, `TWS_OFS_ADDR_CMP) ? address_compare_register_reg :
      hit(avs_address, `TWS_OFS_CLK_LATCH) ?
         {7'h00, clock_pin_output_latch_reg} :
      hit(avs_address, `TWS_OFS_IRQ_STAT) ? {6'h00, irq_stat_reg} :
      hit(avs_address, `TWS_OFS_IRQ_EN) ? {6'h00, irq_en_reg} :
      hit(avs_address, `TWS_OFS_TX_COPY) ? tx_copy_reg : 8'h00;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         ack_reg <= access && !ack_reg;
         if (rd_take) begin
            avs_readdata <= {24'h000000, rd_byte};
         end
      end
   end

   // serial clock edges: the external clock is only seen after synchronising
   assign ext_rise = !sck_prev_reg && pin_sync[2];
   assign ext_fall = sck_prev_reg && !pin_sync[2];
   assign clk_bus.run = busy && int_clk;
   assign sck_rise = int_clk ? clk_bus.rise : ext_rise;
   assign sck_fall = int_clk ? clk_bus.fall : ext_fall;
   assign din = pin_sel ? pin_sync[1] : pin_sync[0];

   // a start needs an idle clock: stopped generator or external line high
   assign can_start = !busy && (int_clk || pin_sync[2]);
   assign start = wr_shift && channel_enable_bit && can_start;
   assign done_evt = busy && sck_rise
      && (bit_cnt_reg == `TWS_LAST_BIT);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (done_evt || !channel_enable_bit) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= `TWS_CNT_RST;
         sck_prev_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         sck_prev_reg <= pin_sync[2];
         if (start) begin
            bit_cnt_reg <= `TWS_CNT_RST;
         end else if (busy && sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
         end
      end
   end

   // shifter: a write while busy is dropped so a frame is never torn
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         serial_shift_register_reg <= `TWS_BYTE_RST;
         tx_copy_reg <= `TWS_BYTE_RST;
      end else if (wr_shift && !busy) begin
         serial_shift_register_reg <= wbyte;
         tx_copy_reg <= wbyte;
      end else if (busy && sck_rise) begin
         serial_shift_register_reg <=
            {serial_shift_register_reg[6:0], din};
      end
   end

   // data output latch: the software triggers only act between transfers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         serial_output_latch_reg <= `TWS_OUT_RST;
      end else if (start) begin
         serial_output_latch_reg <= wbyte[7];
      end else if (busy && sck_fall) begin
         serial_output_latch_reg <= serial_shift_register_reg[7];
      end else if (!busy && data_line_set_trigger) begin
         serial_output_latch_reg <= 1'b1;
      end else if (!busy && data_line_clear_trigger) begin
         serial_output_latch_reg <= 1'b0;
      end
   end

   // open drain: only a zero pulls the selected line low
   assign data_bus_pin_a_out = 1'b0;
   assign data_bus_pin_b_out = 1'b0;
   assign data_bus_pin_a_oe = !pin_sel && !serial_output_latch_reg;
   assign data_bus_pin_b_oe = pin_sel && !serial_output_latch_reg;

   // clock pin, internal clock mode only: generator while shifting, software latch otherwise
   assign clk_level = busy ? clk_bus.level : clock_pin_output_latch_reg;
   assign serial_clock_pin_out = 1'b0;
   assign serial_clock_pin_oe = int_clk && !clk_level;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         channel_mode_register_reg <= `TWS_MODE_RST;
         address_compare_register_reg <= `TWS_BYTE_RST;
         clock_pin_output_latch_reg <= `TWS_LATCH_RST;
         compare_match_flag_reg <= 1'b0;
      end else begin
         if (wr_mode) begin
            channel_mode_register_reg <= wbyte & `TWS_MODE_WMASK;
         end
         if (wr_addr_cmp) begin
            address_compare_register_reg <= wbyte;
         end
         if (wr_clk_latch) begin
            clock_pin_output_latch_reg <= wbyte[0];
         end
         // comparator runs all the time; forced low while disabled
         compare_match_flag_reg <= channel_enable_bit
            && (serial_shift_register_reg
                == address_compare_register_reg);
      end
   end

   // interrupts: sticky status, set beats a clear in the same cycle
   assign irq_set[`TWS_IRQ_DONE] = done_evt;
   assign irq_set[`TWS_IRQ_TXERR] = done_evt
      && ({serial_shift_register_reg[6:0], din} != tx_copy_reg);
   assign irq_clr = wr_irq_clr ? wbyte[`TWS_IRQ_W-1:0] : `TWS_IRQ_RST;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_stat_reg <= `TWS_IRQ_RST;
         irq_en_reg <= `TWS_IRQ_RST;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         if (wr_irq_en) begin
            irq_en_reg <= wbyte[`TWS_IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_no_start_disabled;
      wr_shift && !channel_enable_bit && !busy |=> !busy;
   endproperty
   a_no_start_disabled: assert property (p_no_start_disabled)
      else $error("shift write started a transfer while disabled");

   property p_start_busy;
      wr_shift && channel_enable_bit && can_start |=> busy;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("enabled shift write did not start a transfer");

   property p_enable_late;
      !busy && !start && wr_mode && wbyte[`TWS_MODE_EN] |=> !busy;
   endproperty
   a_enable_late: assert property (p_enable_late)
      else $error("setting enable started a transfer");

   property p_release_one;
      serial_output_latch_reg |-> !data_bus_pin_a_oe && !data_bus_pin_b_oe;
   endproperty
   a_release_one: assert property (p_release_one)
      else $error("data pin driven for a one bit");

   property p_done;
      done_evt |=> !busy && irq_stat_reg[`TWS_IRQ_DONE];
   endproperty
   a_done: assert property (p_done)
      else $error("transfer did not stop with done flag set");

   property p_capture;
      busy && sck_rise |=> serial_shift_register_reg[0] == $past(din);
   endproperty
   a_capture: assert property (p_capture)
      else $error("rising edge did not capture the bus level");

   property p_match;
      ##1 compare_match_flag_reg == ($past(channel_enable_bit)
         && $past(serial_shift_register_reg)
            == $past(address_compare_register_reg));
   endproperty
   a_match: assert property (p_match)
      else $error("compare match flag wrong");

   property p_msb_first;
      start |=> serial_output_latch_reg == $past(wbyte[7]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first bit on the line is not the msb");

   property p_static_clock;
      !busy && int_clk |-> serial_clock_pin_oe == !clock_pin_output_latch_reg;
   endproperty
   a_static_clock: assert property (p_static_clock)
      else $error("idle clock pin does not follow the latch");

   property p_set_wins;
      done_evt && wr_irq_clr && wbyte[`TWS_IRQ_DONE]
         |=> irq_stat_reg[`TWS_IRQ_DONE];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("done event lost against a clear");

   property p_bus_answer;
      access && !ack_reg |=> !avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus access not answered after one wait state");
endmodule
`default_nettype wire

//--- tws_map.svh
// register map, field positions and reset values of the two-wire serial block
// assumes: included by bare name from the core module and the bench
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_OFS_MODE 6'h00
`define TWS_OFS_BUS_CTRL 6'h04
`define TWS_OFS_SHIFT 6'h08
`define TWS_OFS_ADDR_CMP 6'h0C
`define TWS_OFS_CLK_LATCH 6'h10
`define TWS_OFS_IRQ_STAT 6'h14
`define TWS_OFS_IRQ_CLR 6'h18
`define TWS_OFS_IRQ_EN 6'h1C
`define TWS_OFS_TX_COPY 6'h20

`define TWS_MODE_EN 7
`define TWS_MODE_MATCH 6
`define TWS_MODE_BUSY 2
`define TWS_MODE_INTCLK 1
`define TWS_MODE_PINSEL 0
`define TWS_MODE_WMASK 8'h83

`define TWS_BC_SET 0
`define TWS_BC_CLR 1

`define TWS_IRQ_DONE 0
`define TWS_IRQ_TXERR 1
`define TWS_IRQ_W 2

`define TWS_MODE_RST 8'h00
`define TWS_BYTE_RST 8'h00
`define TWS_IRQ_RST 2'h0
`define TWS_LATCH_RST 1'b1
`define TWS_OUT_RST 1'b1
`define TWS_LAST_BIT 3'h7
`define TWS_CNT_RST 3'h0

`endif

//--- tws_pkg.sv
// shared types of the two-wire serial block
// assumes: map header tws_map.svh sits in the same folder
package tws_pkg;
   typedef logic [5:0] tws_addr_t;
   typedef logic [31:0] tws_word_t;
   typedef logic [7:0] tws_byte_t;
   typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} tws_state_t;
endpackage

//--- tws_clk_if.sv
// carries the internal serial clock between its generator and the core
// assumes: one generator drives level and edge pulses, the core drives run
`timescale 1ns/1ps
`default_nettype none
interface tws_clk_if;
   logic run;
   logic level;
   logic fall;
   logic rise;
   modport gen (input run, output level, output fall, output rise);
   modport core (output run, input level, input fall, input rise);
endinterface
`default_nettype wire

//--- tws_sync.sv
// two flip-flop synchroniser for pin levels
// assumes: inputs are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
   parameter int WIDTH = 3
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] stable_reg;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("tws_sync: WIDTH must be at least 1");
      end
   endgenerate

   // pins idle high under pull-ups, so reset to ones
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '1;
         stable_reg <= '1;
      end else begin
         meta_reg <= async_in;
         stable_reg <= meta_reg;
      end
   end

   assign sync_out = stable_reg;
endmodule
`default_nettype wire

//--- tws_clkgen.sv
// internal serial clock: idles high, toggles every HALF cycles while run
// assumes: run drops in the cycle after the last rise pulse
`timescale 1ns/1ps
`default_nettype none
module tws_clkgen #(
   parameter int HALF = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   tws_clk_if.gen clk_port
);
   localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
   localparam logic [CW-1:0] LAST = CW'(HALF - 1);
   logic [CW-1:0] cnt_reg;
   logic level_reg;
   logic wrap;

   generate
      if (HALF < 3) begin : g_bad_half
         $error("tws_clkgen: HALF below 3 leaves no time to sample");
      end
   endgenerate

   assign wrap = clk_port.run && (cnt_reg == LAST);
   assign clk_port.fall = wrap && level_reg;
   assign clk_port.rise = wrap && !level_reg;
   assign clk_port.level = level_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         level_reg <= 1'b1;
      end else if (!clk_port.run) begin
         cnt_reg <= '0;
         level_reg <= 1'b1;
      end else if (wrap) begin
         cnt_reg <= '0;
         level_reg <= !level_reg;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- tws_partner.sv
// partner device on the two-wire bus: byte shifter plus optional clock
// assumes: bench resolves the open-drain wires with pull-ups
`timescale 1ns/1ps
`default_nettype none
module tws_partner (
   input wire logic sck,
   input wire logic sda,
   input wire logic load,
   input wire logic ext_clk,
   input wire tws_pkg::tws_byte_t tx_byte,
   output logic clk_oe,
   output logic data_oe,
   output tws_pkg::tws_byte_t rx_byte
);
   import tws_pkg::*;
   tws_byte_t sh;
   int rises;
   initial begin
      clk_oe = 1'b0;
      data_oe = 1'b0;
      sh = 8'hFF;
      rises = 8;
      rx_byte = 8'h00;
   end
   // a pure receiver is loaded with all ones so it never pulls
   always @(posedge load) begin
      sh = tx_byte;
      rises = 0;
      data_oe = ~tx_byte[7]; // msb first
   end
   // clock runs only inside a frame; the line idles high otherwise
   always @(posedge ext_clk) begin
      #7;
      repeat (8) begin
         clk_oe = 1'b1;
         #24;
         clk_oe = 1'b0;
         #24;
      end
   end
   always @(negedge sck) begin
      if (rises < 8) data_oe = ~sh[7];
   end
   always @(posedge sck) begin
      if (rises < 8) begin
         sh = {sh[6:0], sda};
         rises = rises + 1;
         rx_byte = sh;
         // release after the last bit so the line floats high
         if (rises == 8) data_oe = 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the two-wire serial block
// assumes: open-drain wires pulled up here; partner model on the bus
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tb_top;
   import tws_pkg::*;
   logic core_clk;
   logic rst;
   tws_addr_t avs_address;
   logic avs_read;
   logic avs_write;
   tws_word_t avs_writedata;
   logic [3:0] avs_byteenable;
   tws_word_t avs_readdata;
   logic avs_waitrequest;
   logic sck_oe;
   logic a_oe;
   logic b_oe;
   logic irq;
   logic [2:0] pin_out;
   logic pin_b;
   logic p_load;
   logic p_ext;
   tws_byte_t p_tx;
   tws_byte_t p_rx;
   logic p_clk_oe;
   logic p_data_oe;
   tws_word_t rdv;
   int n_fail;
   int checks_done;
   int n_fall;
   wire sck;
   wire sda_a;
   wire sda_b;
   wire sda_p;
   assign sck = ~(sck_oe | p_clk_oe);
   assign sda_a = ~(a_oe | (~pin_b & p_data_oe));
   assign sda_b = ~(b_oe | (pin_b & p_data_oe));
   assign sda_p = pin_b ? sda_b : sda_a;
   tws_two_wire_io #(.SCK_HALF(8)) uut (
      .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .serial_clock_pin_in(sck), .serial_clock_pin_out(pin_out[2]),
      .serial_clock_pin_oe(sck_oe), .data_bus_pin_a_in(sda_a),
      .data_bus_pin_a_out(pin_out[0]), .data_bus_pin_a_oe(a_oe),
      .data_bus_pin_b_in(sda_b), .data_bus_pin_b_out(pin_out[1]),
      .data_bus_pin_b_oe(b_oe), .irq(irq)
   );
   tws_partner peer (
      .sck(sck), .sda(sda_p), .load(p_load), .ext_clk(p_ext),
      .tx_byte(p_tx), .clk_oe(p_clk_oe), .data_oe(p_data_oe),
      .rx_byte(p_rx)
   );
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;
   always @(negedge sck) n_fall++;
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // every access starts one edge later, so no strobe is set twice
   task automatic wr(input tws_addr_t a, input tws_byte_t d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic rd(input tws_addr_t a);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic rchk(input tws_addr_t a, input tws_byte_t e,
                       input string what);
      rd(a);
      chk(what, rdv, {24'h0, e});
   endtask
   task automatic pload(input tws_byte_t b);
      @(posedge core_clk);
      p_tx <= b;
      p_load <= 1'b1;
      @(posedge core_clk);
      p_load <= 1'b0;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 300; i++) begin
         rd(`TWS_OFS_MODE);
         if (rdv[`TWS_MODE_BUSY] === 1'b0) break;
      end
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge core_clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      $display("[FAIL] watchdog expected finish seen timeout");
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      pin_b = 1'b0;
      p_load = 1'b0;
      p_ext = 1'b0;
      p_tx = 8'hFF;
      n_fail = 0;
      checks_done = 0;
      n_fall = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rchk(`TWS_OFS_MODE, 8'h00, "mode reset");
      rchk(`TWS_OFS_CLK_LATCH, 8'h01, "clock latch reset");
      rchk(`TWS_OFS_IRQ_STAT, 8'h00, "status reset");
      rchk(`TWS_OFS_BUS_CTRL, 8'h00, "bus ctrl read");
      rchk(6'h3C, 8'h00, "unmapped read");
      chk("clock idle", 32'(sck_oe), 32'h0);
      chk("open drain outs", 32'(pin_out), 32'h0);
      $display("test reset done");
      // a write while disabled must not start later on enable
      wr(`TWS_OFS_MODE, 8'h02);
      wr(`TWS_OFS_SHIFT, 8'h5A);
      wr(`TWS_OFS_MODE, 8'h82);
      repeat (40) @(posedge core_clk);
      chk("no clock pulses", 32'(n_fall), 32'h0);
      rchk(`TWS_OFS_MODE, 8'h82, "mode not busy");
      rchk(`TWS_OFS_IRQ_STAT, 8'h00, "no done");
      $display("test late enable done");
      wr(`TWS_OFS_IRQ_EN, 8'h01);
      pload(8'hFF);
      wr(`TWS_OFS_ADDR_CMP, 8'hA5);
      n_fall = 0;
      wr(`TWS_OFS_SHIFT, 8'hA5);
      wait_irq();
      chk("irq on done", 32'(irq), 32'h1);
      chk("clock pulses", 32'(n_fall), 32'h8);
      chk("peer byte", 32'(p_rx), 32'hA5);
      rchk(`TWS_OFS_SHIFT, 8'hA5, "bus readback");
      rchk(`TWS_OFS_MODE, 8'hC2, "match set");
      rchk(`TWS_OFS_IRQ_STAT, 8'h01, "done only");
      chk("clock high idle", 32'(sck), 32'h1);
      wr(`TWS_OFS_IRQ_CLR, 8'h03);
      @(posedge core_clk);
      chk("irq cleared", 32'(irq), 32'h0);
      wr(`TWS_OFS_IRQ_EN, 8'h00);
      $display("test internal transfer done");
      // peer pulls the upper nibble, so the bus reads all zeros
      pload(8'h0F);
      wr(`TWS_OFS_ADDR_CMP, 8'hF0);
      wr(`TWS_OFS_SHIFT, 8'hF0);
      wr(`TWS_OFS_SHIFT, 8'h33);
      wait_idle();
      rchk(`TWS_OFS_SHIFT, 8'h00, "wired-and readback");
      rchk(`TWS_OFS_TX_COPY, 8'hF0, "busy write ignored");
      rchk(`TWS_OFS_MODE, 8'h82, "match cleared");
      rchk(`TWS_OFS_IRQ_STAT, 8'h03, "tx error");
      chk("peer sees zeros", 32'(p_rx), 32'h0);
      chk("irq masked", 32'(irq), 32'h0);
      wr(`TWS_OFS_IRQ_EN, 8'h03);
      @(posedge core_clk);
      chk("irq unmasked", 32'(irq), 32'h1);
      wr(`TWS_OFS_IRQ_CLR, 8'h03);
      @(posedge core_clk);
      chk("irq cleared", 32'(irq), 32'h0);
      @(posedge core_clk);
      avs_byteenable <= 4'hE;
      wr(`TWS_OFS_ADDR_CMP, 8'h11);
      avs_byteenable <= 4'hF;
      rchk(`TWS_OFS_ADDR_CMP, 8'hF0, "masked write ignored");
      $display("test transmit error done");
      // data triggers written only while idle
      @(posedge core_clk);
      pin_b <= 1'b1;
      wr(`TWS_OFS_MODE, 8'h83);
      wr(`TWS_OFS_BUS_CTRL, 8'h01);
      @(posedge core_clk);
      chk("pin b released", 32'(b_oe), 32'h0);
      wr(`TWS_OFS_BUS_CTRL, 8'h02);
      @(posedge core_clk);
      chk("pin b pulled", 32'(b_oe), 32'h1);
      chk("pin a free", 32'(a_oe), 32'h0);
      wr(`TWS_OFS_MODE, 8'h81);
      pload(8'hFF);
      wr(`TWS_OFS_SHIFT, 8'h3C);
      @(posedge core_clk);
      p_ext <= 1'b1;
      @(posedge core_clk);
      p_ext <= 1'b0;
      wait_irq();
      chk("peer byte ext", 32'(p_rx), 32'h3C);
      rchk(`TWS_OFS_SHIFT, 8'h3C, "ext readback");
      rchk(`TWS_OFS_IRQ_STAT, 8'h01, "ext done");
      wr(`TWS_OFS_IRQ_CLR, 8'h03);
      $display("test external clock done");
      @(posedge core_clk);
      pin_b <= 1'b0;
      wr(`TWS_OFS_MODE, 8'h82);
      wr(`TWS_OFS_CLK_LATCH, 8'h00);
      @(posedge core_clk);
      chk("clock held low", 32'(sck), 32'h0);
      wr(`TWS_OFS_CLK_LATCH, 8'h01);
      @(posedge core_clk);
      chk("clock let go", 32'(sck_oe), 32'h0);
      $display("test clock latch done");
      wrap_up();
   end
endmodule
`default_nettype wire
